// >>> include/opamp_cfg.svh
// Register map, field positions, reset values and widths of the amplifier
// control block. Included by the package, the control module and the bench.
`ifndef OPAMP_CFG_SVH
`define OPAMP_CFG_SVH

// Byte offsets on the register bus
`define AMP_CONTROL_OFFSET 8'h00
`define CHAN_SELECT_OFFSET 8'h04
`define PIN_IO_OFFSET 8'h08

// Control register fields
`define AMP_ON_BIT 7
`define LEVEL_BIT 6
`define TRIM_MODE_BIT 5
`define TRIM_REF_BIT 4
`define TRIM_LSB 0
`define TRIM_W 4

// Channel select field
`define CHAN_SEL_W 3
`define CHAN_FIRST_ADC 3'h1
`define CHAN_LAST_ADC 3'h5

// Pin I/O register fields
`define PIN_OUT_BIT 0
`define PIN_DRIVE_BIT 1
`define PIN_LEVEL_BIT 2

// Reset values
`define AMP_CONTROL_RESET 8'h00
`define CHAN_SELECT_RESET 3'h0
`define PIN_IO_RESET 2'h0

`endif

// >>> include/opamp_pkg.sv
// Types shared by the amplifier control block and its pin decoder.
// Assumes opamp_cfg.svh on the include path.
`include "opamp_cfg.svh"

package opamp_pkg;

  typedef logic [`CHAN_SEL_W-1:0] chan_sel_t;
  typedef logic [`TRIM_W-1:0] trim_t;

  typedef enum logic [2:0] {
    PIN_DIGITAL_IO,
    PIN_DIGITAL_IN,
    PIN_ADC_IN,
    PIN_AMP_OUT,
    PIN_AMP_OUT_ADC
  } pin_func_e;

endpackage

// >>> include/pin_ctrl_if.sv
// Signals between the control block and its pin function decoder.
// Assumes opamp_pkg compiled first.
`timescale 1ns/100ps

interface pin_ctrl_if;
  import opamp_pkg::*;

  logic option_en;
  logic amp_on_bit;
  chan_sel_t converter_channel_select;
  pin_func_e pin_func;
  logic amp_run;

  modport owner (
    output option_en,
    output amp_on_bit,
    output converter_channel_select,
    input pin_func,
    input amp_run
  );

  modport decoder (
    input option_en,
    input amp_on_bit,
    input converter_channel_select,
    output pin_func,
    output amp_run
  );
endinterface

// >>> hdl/pin_function_decode.sv
// Decodes build option, enable bit and channel select into a pin function.
// Assumes pin_ctrl_if and opamp_pkg; purely combinational.
`timescale 1ns/100ps

module pin_function_decode (
  // Control inputs and decoded function
  pin_ctrl_if.decoder ctl
);
  import opamp_pkg::*;

  logic adc_code;

  always_comb begin
    adc_code = (ctl.converter_channel_select >= `CHAN_FIRST_ADC) &&
               (ctl.converter_channel_select <= `CHAN_LAST_ADC);
    ctl.amp_run = 1'b0;
    ctl.pin_func = PIN_DIGITAL_IO;
    case ({ctl.option_en, ctl.amp_on_bit})
      2'b10: begin
        ctl.pin_func = adc_code ? PIN_ADC_IN : PIN_DIGITAL_IN; // RQ2 RQ3
      end
      2'b11: begin
        ctl.amp_run = 1'b1;
        ctl.pin_func = adc_code ? PIN_AMP_OUT_ADC : PIN_AMP_OUT; // RQ4 RQ5
      end
      default: begin
        ctl.pin_func = adc_code ? PIN_ADC_IN : PIN_DIGITAL_IO; // RQ1
      end
    endcase
  end
endmodule

// >>> hdl/opamp_control_pinmux.sv
// Amplifier control register, pin function logic and APB slave.
// Assumes a 20 MHz pclk; level and pin inputs are asynchronous to it.
//
// Overview of operation
// RQ1: Option disabled keeps amplifier off; code 000 digital I/O, 001-101 ADC.
// RQ2: Option on, enable 0, code 000: amplifier off, pin digital input.
// RQ3: Option on, enable 0, code 001-101: amplifier off, pin to ADC.
// RQ4: Option on, enable 1, code 000: amplifier on, drives the pin.
// RQ5: Option on, enable 1, code 001-101: amplifier drives pin and ADC.
// RQ6: Software must not set enable with option off; readback undefined.
// RQ7: Control bit 7 switches the amplifier on (1) or off (0).
// RQ8: Control bit 6 shows amplifier output level, read only.
// RQ9: Control bit 5 selects offset cancellation (1) or normal mode (0).
// RQ10: Control bit 4 picks noninverting (1) or inverting (0) reference.
// RQ11: Control bits 0 to 3 are the four-bit offset trim code.
// RQ12: Software calibrates by stepping trim until the level bit flips.
// RQ13: Level bit reads 0 while the amplifier is off.
`timescale 1ns/100ps
`include "opamp_cfg.svh"

module opamp_control_pinmux #(
  parameter int ADDR_W = 8,
  parameter bit AMP_OPTION = 1'b1
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog amplifier controls
  input wire logic amp_output_level,
  output logic amp_power_on,
  output logic amp_trim_mode_en,
  output logic amp_ref_noninv_close,
  output logic amp_ref_inv_close,
  output opamp_pkg::trim_t amp_trim_code,
  // Shared analog pin routing
  input wire logic shared_analog_pin_in,
  output logic shared_analog_pin_out,
  output logic shared_analog_pin_oe,
  output logic pin_digital_in_en,
  output logic pin_drive_amp,
  output logic adc_ch0_from_pin,
  output logic adc_ch0_from_amp
);
  import opamp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic amp_on_bit;
  logic trim_mode_select;
  logic trim_reference_select;
  trim_t offset_trim_code;
  chan_sel_t converter_channel_select;
  logic pin_out_data;
  logic pin_drive_en;
  logic level_meta;
  logic level_sync;
  logic pin_meta;
  logic pin_sync;
  pin_func_e pin_func;
  logic setup_phase;
  logic write_take;
  logic ctrl_write;
  logic [31:0] next_prdata;

  pin_ctrl_if ctl ();

  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] offset);
    addr_is = (a == ADDR_W'(offset));
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = addr_is(a, `AMP_CONTROL_OFFSET) ||
                  addr_is(a, `CHAN_SELECT_OFFSET) ||
                  addr_is(a, `PIN_IO_OFFSET);
  endfunction

  assign setup_phase = psel && !penable;
  assign write_take = psel && penable && pready && pwrite;
  assign ctrl_write = write_take && addr_is(paddr, `AMP_CONTROL_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_meta <= 1'b0;
      level_sync <= 1'b0;
    end else begin
      level_meta <= amp_output_level;
      level_sync <= level_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= shared_analog_pin_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_on_bit <= 1'(`AMP_CONTROL_RESET >> `AMP_ON_BIT);
      trim_mode_select <= 1'(`AMP_CONTROL_RESET >> `TRIM_MODE_BIT);
      trim_reference_select <= 1'(`AMP_CONTROL_RESET >> `TRIM_REF_BIT);
      offset_trim_code <= trim_t'(`AMP_CONTROL_RESET);
    end else if (write_take && addr_is(paddr, `AMP_CONTROL_OFFSET)) begin
      amp_on_bit <= pwdata[`AMP_ON_BIT]; // RQ7
      trim_mode_select <= pwdata[`TRIM_MODE_BIT]; // RQ9
      trim_reference_select <= pwdata[`TRIM_REF_BIT]; // RQ10
      offset_trim_code <= pwdata[`TRIM_LSB +: `TRIM_W]; // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel select and pin data registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_channel_select <= `CHAN_SELECT_RESET;
    end else if (write_take && addr_is(paddr, `CHAN_SELECT_OFFSET)) begin
      converter_channel_select <= pwdata[`CHAN_SEL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pin_drive_en, pin_out_data} <= `PIN_IO_RESET;
    end else if (write_take && addr_is(paddr, `PIN_IO_OFFSET)) begin
      pin_out_data <= pwdata[`PIN_OUT_BIT];
      pin_drive_en <= pwdata[`PIN_DRIVE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin function decoder

  assign ctl.option_en = AMP_OPTION;
  assign ctl.amp_on_bit = amp_on_bit;
  assign ctl.converter_channel_select = converter_channel_select;

  pin_function_decode u_decode (
    .ctl(ctl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered analog and pin controls

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_func <= PIN_DIGITAL_IO;
      amp_power_on <= 1'b0;
      amp_trim_code <= '0;
      amp_trim_mode_en <= 1'b0;
      amp_ref_noninv_close <= 1'b0;
      amp_ref_inv_close <= 1'b0;
    end else begin
      pin_func <= ctl.pin_func;
      amp_power_on <= ctl.amp_run; // RQ1 RQ7
      amp_trim_code <= offset_trim_code; // RQ11
      amp_trim_mode_en <= trim_mode_select; // RQ9
      amp_ref_noninv_close <= trim_mode_select && trim_reference_select; // RQ10
      amp_ref_inv_close <= trim_mode_select && !trim_reference_select; // RQ10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_analog_pin_out <= 1'b0;
      shared_analog_pin_oe <= 1'b0;
      pin_digital_in_en <= 1'b0;
      pin_drive_amp <= 1'b0;
      adc_ch0_from_pin <= 1'b0;
      adc_ch0_from_amp <= 1'b0;
    end else begin
      shared_analog_pin_out <= pin_out_data;
      shared_analog_pin_oe <= (ctl.pin_func == PIN_DIGITAL_IO) &&
                              pin_drive_en; // RQ1 RQ2
      pin_digital_in_en <= (ctl.pin_func == PIN_DIGITAL_IO) ||
                           (ctl.pin_func == PIN_DIGITAL_IN); // RQ2
      pin_drive_amp <= (ctl.pin_func == PIN_AMP_OUT) ||
                       (ctl.pin_func == PIN_AMP_OUT_ADC); // RQ4 RQ5
      adc_ch0_from_pin <= (ctl.pin_func == PIN_ADC_IN); // RQ3
      adc_ch0_from_amp <= (ctl.pin_func == PIN_AMP_OUT_ADC); // RQ5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data and answer

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (addr_is(paddr, `AMP_CONTROL_OFFSET)) begin
      next_prdata[`AMP_ON_BIT] = amp_on_bit;
      next_prdata[`LEVEL_BIT] = amp_power_on && level_sync; // RQ8 RQ13
      next_prdata[`TRIM_MODE_BIT] = trim_mode_select;
      next_prdata[`TRIM_REF_BIT] = trim_reference_select;
      next_prdata[`TRIM_LSB +: `TRIM_W] = offset_trim_code;
    end else if (addr_is(paddr, `CHAN_SELECT_OFFSET)) begin
      next_prdata[`CHAN_SEL_W-1:0] = converter_channel_select;
    end else if (addr_is(paddr, `PIN_IO_OFFSET)) begin
      next_prdata[`PIN_OUT_BIT] = pin_out_data;
      next_prdata[`PIN_DRIVE_BIT] = pin_drive_en;
      next_prdata[`PIN_LEVEL_BIT] = pin_sync && pin_digital_in_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !addr_mapped(paddr);
      if (setup_phase && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ctrl_write;
    ctrl_write;
  endsequence

  sequence s_ctrl_write_alone;
    s_ctrl_write ##1 !ctrl_write;
  endsequence

  sequence s_ctrl_read_setup;
    setup_phase && !pwrite && addr_is(paddr, `AMP_CONTROL_OFFSET);
  endsequence

  a_apb_ready_timing: assert property (
    setup_phase |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");

  a_option_off_amp: assert property ( // RQ1
    !AMP_OPTION |-> !amp_power_on && !pin_drive_amp && !adc_ch0_from_amp)
    else $error("amplifier active with option disabled");

  a_digital_in_only: assert property ( // RQ2
    presetn && AMP_OPTION && !amp_on_bit &&
    converter_channel_select == 3'h0
    |=> pin_digital_in_en && !shared_analog_pin_oe && !amp_power_on)
    else $error("pin not a plain digital input");

  a_adc_pin_route: assert property ( // RQ3
    !amp_on_bit && converter_channel_select >= `CHAN_FIRST_ADC &&
    converter_channel_select <= `CHAN_LAST_ADC
    |=> adc_ch0_from_pin && !amp_power_on && !shared_analog_pin_oe)
    else $error("pin not routed to converter channel 0");

  a_amp_pin_only: assert property ( // RQ4
    AMP_OPTION && amp_on_bit && converter_channel_select == 3'h0
    |=> amp_power_on && pin_drive_amp && !adc_ch0_from_amp &&
        !shared_analog_pin_oe)
    else $error("amplifier not driving the pin alone");

  a_amp_pin_adc: assert property ( // RQ5
    AMP_OPTION && amp_on_bit && converter_channel_select >= `CHAN_FIRST_ADC
    && converter_channel_select <= `CHAN_LAST_ADC
    |=> amp_power_on && pin_drive_amp && adc_ch0_from_amp && !adc_ch0_from_pin)
    else $error("amplifier not feeding pin and converter");

  a_enable_write: assert property ( // RQ7
    s_ctrl_write_alone
    |-> ##1 amp_power_on == (AMP_OPTION && $past(pwdata[`AMP_ON_BIT], 2)))
    else $error("enable bit write not applied");

  a_level_readback: assert property ( // RQ8
    s_ctrl_read_setup
    |=> prdata[`LEVEL_BIT] == $past(amp_power_on && level_sync))
    else $error("level bit read does not follow amplifier output");

  a_level_off_zero: assert property ( // RQ13
    s_ctrl_read_setup and !amp_power_on |=> !prdata[`LEVEL_BIT])
    else $error("level bit nonzero while amplifier off");

  a_trim_mode_ref: assert property ( // RQ9
    s_ctrl_write_alone
    |-> ##1 amp_trim_mode_en == $past(pwdata[`TRIM_MODE_BIT], 2) &&
        amp_ref_noninv_close == ($past(pwdata[`TRIM_MODE_BIT], 2) &&
                                 $past(pwdata[`TRIM_REF_BIT], 2)))
    else $error("trim mode or reference not applied");

  a_ref_exclusive: assert property ( // RQ10
    !(amp_ref_noninv_close && amp_ref_inv_close) &&
    (amp_ref_noninv_close || amp_ref_inv_close) == amp_trim_mode_en)
    else $error("reference switches inconsistent with mode");

  a_trim_applied: assert property ( // RQ11
    s_ctrl_write_alone
    |-> ##1 amp_trim_code == $past(pwdata[`TRIM_W-1:0], 2))
    else $error("trim code not applied");

  a_unmapped_error: assert property (
    setup_phase && !addr_mapped(paddr) |=> pready && pslverr)
    else $error("unmapped address not answered with an error");

  a_mapped_no_error: assert property (
    setup_phase && addr_mapped(paddr) |=> pready && !pslverr)
    else $error("error answer on a mapped address");

  a_oe_digital_only: assert property ( // RQ1
    shared_analog_pin_oe |-> pin_digital_in_en && !pin_drive_amp &&
    !adc_ch0_from_pin)
    else $error("pin driven outside digital I/O function");

endmodule

// >>> bench/tb_opamp_control_pinmux.sv
// Self-checking bench for the amplifier control block over APB.
// Assumes opamp_pkg, opamp_cfg.svh and the design compiled first.
`timescale 1ns/100ps
`include "opamp_cfg.svh"

module tb_opamp_control_pinmux;
  import opamp_pkg::*;

  typedef struct {logic [31:0] d; logic err; logic rd;} note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic level, pin_in, pwr, mode_en, ref_hi, ref_lo;
  logic pin_out, pin_oe, dig_en, drv_amp, adc_pin, adc_amp;
  logic [5:0] exp_r;
  trim_t trim_code;
  wire [5:0] off_route;
  note_s notes[$];
  note_s head;
  int failures = 0;
  int num_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and design instances
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  opamp_control_pinmux #(.ADDR_W(8), .AMP_OPTION(1'b1)) i_opamp_control_pinmux (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .amp_output_level(level),
    .amp_power_on(pwr), .amp_trim_mode_en(mode_en),
    .amp_ref_noninv_close(ref_hi), .amp_ref_inv_close(ref_lo),
    .amp_trim_code(trim_code), .shared_analog_pin_in(pin_in),
    .shared_analog_pin_out(pin_out), .shared_analog_pin_oe(pin_oe),
    .pin_digital_in_en(dig_en), .pin_drive_amp(drv_amp),
    .adc_ch0_from_pin(adc_pin), .adc_ch0_from_amp(adc_amp));

  // Build option off: shares the bus, only its routing is watched
  opamp_control_pinmux #(.ADDR_W(8), .AMP_OPTION(1'b0)) i_opamp_control_pinmux_off (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(),
    .pwdata(pwdata & 32'hFFFF_FF7F),
    .pready(), .pslverr(), .amp_output_level(level),
    .amp_power_on(off_route[5]), .amp_trim_mode_en(),
    .amp_ref_noninv_close(), .amp_ref_inv_close(), .amp_trim_code(),
    .shared_analog_pin_in(pin_in), .shared_analog_pin_out(),
    .shared_analog_pin_oe(off_route[0]), .pin_digital_in_en(off_route[1]),
    .pin_drive_amp(off_route[4]), .adc_ch0_from_pin(off_route[2]),
    .adc_ch0_from_amp(off_route[3]));

  ////////////////////////////////////////////////////////////////////////////
  // Checking and bus tasks
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] ed, input logic ee);
    int n;
    @(posedge pclk);
    notes.push_back('{ed, ee, !wr});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("MISMATCH at %0t: no ready", $time);
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(negedge pclk);
  endtask

  function automatic logic [5:0] route(input bit opt, input bit en,
                                       input logic [2:0] ch);
    bit adc;
    adc = (ch >= `CHAN_FIRST_ADC && ch <= `CHAN_LAST_ADC);
    if (opt && en) return {2'b11, adc, 3'b000};
    if (opt) return {3'b000, adc, !adc, 1'b0};
    return {3'b000, adc, !adc, !adc};
  endfunction

  // Takes the oldest note whenever a transfer completes
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (notes.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        head = notes.pop_front();
        if (head.rd) begin
          chk(prdata, head.d);
        end
        chk({31'h0, pslverr}, {31'h0, head.err});
      end
    end
  end

  initial begin
    #2000000;
    failures++;
    $display("MISMATCH at %0t: watchdog", $time);
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 1'b0;
    pin_in = 1'b0;
    void'($urandom(32'h189a3e0d));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `AMP_CONTROL_OFFSET, 32'h0, 32'h0, 1'b0);
    apb(1'b0, `CHAN_SELECT_OFFSET, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h0C, 32'hFF, 32'h0, 1'b1);
    apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
    apb(1'b1, `PIN_IO_OFFSET, 32'h3, 32'h0, 1'b0);
    // Every enable and channel code on the option-on build, every channel code with enable 0 on the option-off build
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge pclk);
        pin_in <= 1'($urandom);
        apb(1'b1, `AMP_CONTROL_OFFSET, 32'(e) << 7, 32'h0, 1'b0);
        apb(1'b1, `CHAN_SELECT_OFFSET, 32'(c), 32'h0, 1'b0);
        settle();
        exp_r = route(1'b1, e[0], c[2:0]);
        chk({26'h0, pwr, drv_amp, adc_amp, adc_pin, dig_en, pin_oe},
            {26'h0, exp_r});
        chk({26'h0, off_route}, {26'h0, route(1'b0, e[0], c[2:0])});
        chk({31'h0, pin_out}, 32'h1);
        apb(1'b0, `CHAN_SELECT_OFFSET, 32'h0, 32'(c), 1'b0);
        apb(1'b0, `PIN_IO_OFFSET, 32'h0, {29'h0, pin_in & exp_r[1], 2'b11},
            1'b0);
      end
    end
    // Random mode, reference and trim with the amplifier on
    apb(1'b1, `CHAN_SELECT_OFFSET, 32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      r = {24'h0, 1'b1, 7'($urandom)};
      @(posedge pclk);
      level <= 1'($urandom);
      apb(1'b1, `AMP_CONTROL_OFFSET, r, 32'h0, 1'b0);
      settle();
      chk({25'h0, mode_en, ref_hi, ref_lo, trim_code},
          {25'h0, r[5], r[5] & r[4], r[5] & !r[4], r[3:0]});
      apb(1'b0, `AMP_CONTROL_OFFSET, 32'h0, {24'h0, 2'b10, r[5:0]} |
          (32'(level) << 6), 1'b0);
    end
    // Amplifier off hides the level, write to it ignored
    @(posedge pclk);
    level <= 1'b1;
    apb(1'b1, `AMP_CONTROL_OFFSET, 32'h7F, 32'h0, 1'b0);
    settle();
    chk({31'h0, pwr}, 32'h0);
    apb(1'b0, `AMP_CONTROL_OFFSET, 32'h0, 32'h3F, 1'b0);
    // Calibration: step all 16 trim codes, level flips at 9, then normal mode
    for (int t = 0; t < 16; t++) begin
      @(posedge pclk);
      level <= (t >= 9);
      apb(1'b1, `AMP_CONTROL_OFFSET, 32'hB0 | 32'(t), 32'h0, 1'b0);
      settle();
      chk({28'h0, trim_code}, 32'(t));
      apb(1'b0, `AMP_CONTROL_OFFSET, 32'h0,
          32'hB0 | 32'(t) | (t >= 9 ? 32'h40 : 32'h0), 1'b0);
    end
    apb(1'b1, `AMP_CONTROL_OFFSET, 32'h80, 32'h0, 1'b0);
    settle();
    chk({30'h0, mode_en, pwr}, 32'h1);
    wrap_up();
  end
endmodule
